/* File: rtl/gpi_port.sv */
// GPIO port of up to 32 pins with peripheral muxing, pad control, pin interrupts and wake.
// Assumes peripheral signals arrive on i_clk and an AXI4-Lite master; pad inputs pass a two-stage synchroniser.
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

module gpi_port #(
  parameter int N_PINS = 32
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire gpi_pkg::gpi_axi_req_t i_axi,
  output gpi_pkg::gpi_axi_rsp_t o_axi,
  input wire logic [N_PINS-1:0] i_pad_in,
  output logic [N_PINS-1:0] o_pad_out,
  output logic [N_PINS-1:0] o_pad_oe_n,
  output logic [N_PINS-1:0] o_pull_up_en,
  output logic [N_PINS-1:0] o_pull_dn_en,
  output logic [N_PINS-1:0] o_drive_hi,
  input wire logic [N_PINS-1:0] i_alt_out,
  input wire logic [N_PINS-1:0] i_alt_oe,
  output logic [N_PINS-1:0] o_alt_in,
  output logic o_irq,
  output logic o_wake
);
  import gpi_pkg::*;

  // The port width must fit the 32-bit register words.
  if (N_PINS < 1 || N_PINS > 32) begin : g_bad_width
    $error("N_PINS must be between 1 and 32");
  end

  // The word index must reach every register of the map; a narrower index
  // would alias high offsets onto low ones.
  if ((1 << GPI_IDX_W) < GPI_NUM_REGS) begin : g_bad_map
    $error("GPI_IDX_W is too narrow for the register map");
  end

  localparam logic [GPI_IDX_W-1:0] IX_FUNC = GPI_IDX_W'(GPI_REG_FUNC_SEL >> 2);
  localparam logic [GPI_IDX_W-1:0] IX_OUT = GPI_IDX_W'(GPI_REG_OUT_VAL >> 2);
  localparam logic [GPI_IDX_W-1:0] IX_OE = GPI_IDX_W'(GPI_REG_OUT_EN >> 2);
  localparam logic [GPI_IDX_W-1:0] IX_IN = GPI_IDX_W'(GPI_REG_IN_VAL >> 2);
  localparam logic [GPI_IDX_W-1:0] IX_PEN = GPI_IDX_W'(GPI_REG_PULL_EN >> 2);
  localparam logic [GPI_IDX_W-1:0] IX_PUP = GPI_IDX_W'(GPI_REG_PULL_UP >> 2);
  localparam logic [GPI_IDX_W-1:0] IX_DRV = GPI_IDX_W'(GPI_REG_DRIVE_HI >> 2);
  localparam logic [GPI_IDX_W-1:0] IX_IEN = GPI_IDX_W'(GPI_REG_INT_EN >> 2);
  localparam logic [GPI_IDX_W-1:0] IX_IEDG = GPI_IDX_W'(GPI_REG_INT_EDGE >> 2);
  localparam logic [GPI_IDX_W-1:0] IX_IPOL = GPI_IDX_W'(GPI_REG_INT_POL >> 2);
  localparam logic [GPI_IDX_W-1:0] IX_IST = GPI_IDX_W'(GPI_REG_INT_STAT >> 2);
  localparam logic [GPI_IDX_W-1:0] IX_WEN = GPI_IDX_W'(GPI_REG_WAKE_EN >> 2);
  localparam logic [GPI_IDX_W-1:0] IX_WRIS = GPI_IDX_W'(GPI_REG_WAKE_RISE >> 2);
  localparam logic [GPI_IDX_W-1:0] IX_WST = GPI_IDX_W'(GPI_REG_WAKE_STAT >> 2);
  localparam logic [GPI_IDX_W-1:0] IX_LAST = GPI_IDX_W'(GPI_NUM_REGS - 1);

  // Plain read/write words, indexed by register number; status words live apart.
  logic [31:0] cfg_r [0:GPI_NUM_REGS-1];
  logic [N_PINS-1:0] int_stat_r;
  logic [N_PINS-1:0] int_stat_nxt;
  logic [N_PINS-1:0] wake_stat_r;
  logic [N_PINS-1:0] wake_stat_nxt;

  // Input synchroniser and edge history.
  logic [N_PINS-1:0] sync1_r;
  logic [N_PINS-1:0] sync2_r;
  logic [N_PINS-1:0] prev_r;

  // Bus holding state.
  logic aw_hold_r;
  logic w_hold_r;
  logic awready_r;
  logic wready_r;
  logic [31:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // Handshake terms and hold flags for the next cycle.
  wire aw_fire = i_axi.awvalid && !aw_hold_r;
  wire w_fire = i_axi.wvalid && !w_hold_r;
  wire aw_have = aw_hold_r || aw_fire;
  wire w_have = w_hold_r || w_fire;
  wire do_write = aw_hold_r && w_hold_r && !bvalid_r;
  wire b_done = bvalid_r && i_axi.bready;
  wire ar_fire = i_axi.arvalid && arready_r;
  wire r_done = rvalid_r && i_axi.rready;
  wire aw_hold_nxt = b_done ? 1'b0 : aw_have;
  wire w_hold_nxt = b_done ? 1'b0 : w_have;

  // Address decoding for both directions.
  wire [GPI_IDX_W-1:0] wr_idx = aw_addr_r[GPI_IDX_W+1:2];
  wire [GPI_IDX_W-1:0] rd_idx = i_axi.araddr[GPI_IDX_W+1:2];
  wire wr_hit = (aw_addr_r[31:GPI_IDX_W+2] == '0) && (wr_idx <= IX_LAST);
  wire rd_hit = (i_axi.araddr[31:GPI_IDX_W+2] == '0) && (rd_idx <= IX_LAST);

  // Byte-lane mask from the write strobes.
  wire [31:0] wr_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire [31:0] wr_clr = w_data_r & wr_mask;
  wire [N_PINS-1:0] ist_clr = (do_write && wr_hit && wr_idx == IX_IST) ? wr_clr[N_PINS-1:0] : '0;
  wire [N_PINS-1:0] wst_clr = (do_write && wr_hit && wr_idx == IX_WST) ? wr_clr[N_PINS-1:0] : '0;

  // Per-pin settings taken from the register words.
  wire [N_PINS-1:0] func_sel = cfg_r[IX_FUNC][N_PINS-1:0];
  wire [N_PINS-1:0] out_val = cfg_r[IX_OUT][N_PINS-1:0];
  wire [N_PINS-1:0] out_en = cfg_r[IX_OE][N_PINS-1:0];
  wire [N_PINS-1:0] pull_en = cfg_r[IX_PEN][N_PINS-1:0];
  wire [N_PINS-1:0] pull_up = cfg_r[IX_PUP][N_PINS-1:0];
  wire [N_PINS-1:0] drv_hi = cfg_r[IX_DRV][N_PINS-1:0];
  wire [N_PINS-1:0] int_en = cfg_r[IX_IEN][N_PINS-1:0];
  wire [N_PINS-1:0] int_edge = cfg_r[IX_IEDG][N_PINS-1:0];
  wire [N_PINS-1:0] int_pol = cfg_r[IX_IPOL][N_PINS-1:0];
  wire [N_PINS-1:0] wake_en = cfg_r[IX_WEN][N_PINS-1:0];
  wire [N_PINS-1:0] wake_rise = cfg_r[IX_WRIS][N_PINS-1:0];

  // Pad drive, direction and trigger terms, one slice per pin.
  logic [N_PINS-1:0] pad_out_nxt;
  logic [N_PINS-1:0] pad_drv_nxt;
  logic [N_PINS-1:0] int_hit;
  logic [N_PINS-1:0] wake_hit;
  for (genvar p = 0; p < N_PINS; p++) begin : g_pin
    wire rise = sync2_r[p] && !prev_r[p];
    wire fall = !sync2_r[p] && prev_r[p];
    // Peripheral signals replace firmware output and direction when selected.
    assign pad_out_nxt[p] = func_sel[p] ? i_alt_out[p] : out_val[p];
    assign pad_drv_nxt[p] = func_sel[p] ? i_alt_oe[p] : out_en[p];
    // Edge mode catches the chosen edge; level mode catches the chosen level.
    assign int_hit[p] = int_edge[p] ? (int_pol[p] ? rise : fall)
                                    : (sync2_r[p] == int_pol[p]);
    assign wake_hit[p] = wake_rise[p] ? rise : fall;
  end

  // Status words: a new event wins over a clear in the same cycle.
  assign int_stat_nxt = (int_stat_r & ~ist_clr) | (int_hit & int_en);
  assign wake_stat_nxt = (wake_stat_r & ~wst_clr) | (wake_hit & wake_en);

  // Read data selection.
  logic [31:0] rd_word;
  always_comb begin
    rd_word = '0;
    // Unmapped reads return zero alongside the error response.
    if (!rd_hit) begin
      rd_word = '0;
    end else if (rd_idx == IX_IN) begin
      rd_word[N_PINS-1:0] = sync2_r;
    end else if (rd_idx == IX_IST) begin
      rd_word[N_PINS-1:0] = int_stat_r;
    end else if (rd_idx == IX_WST) begin
      rd_word[N_PINS-1:0] = wake_stat_r;
    end else begin
      rd_word[N_PINS-1:0] = cfg_r[rd_idx][N_PINS-1:0];
    end
  end

  // Two-stage input synchroniser and edge history.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else if (i_ce) begin
      sync1_r <= i_pad_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Configuration words; writes land whenever a write completes, at any time.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < GPI_NUM_REGS; i++) begin
        cfg_r[i] <= GPI_RST_VAL;
      end
    end else if (i_ce) begin
      if (do_write && wr_hit && wr_idx != IX_IN && wr_idx != IX_IST && wr_idx != IX_WST) begin
        cfg_r[wr_idx] <= (cfg_r[wr_idx] & ~wr_mask) | (w_data_r & wr_mask);
      end
    end
  end

  // Latched interrupt and wake status.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      int_stat_r <= '0;
      wake_stat_r <= '0;
    end else if (i_ce) begin
      int_stat_r <= int_stat_nxt;
      wake_stat_r <= wake_stat_nxt;
    end
  end

  // Registered pad controls; pulls apply only while the pad is not driven.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pad_out <= '0;
      o_pad_oe_n <= '1;
      o_pull_up_en <= '0;
      o_pull_dn_en <= '0;
      o_drive_hi <= '0;
      o_alt_in <= '0;
    end else if (i_ce) begin
      o_pad_out <= pad_out_nxt;
      o_pad_oe_n <= ~pad_drv_nxt;
      o_pull_up_en <= pull_en & pull_up & ~pad_drv_nxt;
      o_pull_dn_en <= pull_en & ~pull_up & ~pad_drv_nxt;
      o_drive_hi <= drv_hi;
      o_alt_in <= sync2_r;
    end
  end

  // Port request lines registered from the next status words, masked by the enables.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
      o_wake <= 1'b0;
    end else if (i_ce) begin
      o_irq <= |(int_stat_nxt & int_en);
      o_wake <= |(wake_stat_nxt & wake_en);
    end
  end

  // Write channels: address and data are held in either order, then answered.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= GPI_RESP_OKAY;
    end else if (i_ce) begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      // Ready flags are registered from the next hold flags, so each is their inverse.
      awready_r <= !aw_hold_nxt;
      wready_r <= !w_hold_nxt;
      if (aw_fire) begin
        aw_addr_r <= i_axi.awaddr;
      end
      if (w_fire) begin
        w_data_r <= i_axi.wdata;
        w_strb_r <= i_axi.wstrb;
      end
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? GPI_RESP_OKAY : GPI_RESP_SLVERR;
      end else if (b_done) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time, answered the cycle after the address.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= GPI_RESP_OKAY;
    end else if (i_ce) begin
      if (ar_fire) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= rd_hit ? GPI_RESP_OKAY : GPI_RESP_SLVERR;
      end else if (r_done) begin
        arready_r <= 1'b1;
        rvalid_r <= 1'b0;
      end
    end
  end

  // Bus answers, all straight from flip-flops.
  assign o_axi.awready = awready_r;
  assign o_axi.wready = wready_r;
  assign o_axi.bvalid = bvalid_r;
  assign o_axi.bresp = bresp_r;
  assign o_axi.arready = arready_r;
  assign o_axi.rvalid = rvalid_r;
  assign o_axi.rdata = rdata_r;
  assign o_axi.rresp = rresp_r;

endmodule

/* File: rtl/gpi_pkg.sv */
// Package for the 32-pin general-purpose I/O port: register map, reset values and bus types.
// Assumes a single system clock and an AXI4-Lite master with 32-bit data.
package gpi_pkg;

  // Byte offsets of the register words.
  localparam logic [31:0] GPI_REG_FUNC_SEL = 32'h0000_0000;
  localparam logic [31:0] GPI_REG_OUT_VAL = 32'h0000_0004;
  localparam logic [31:0] GPI_REG_OUT_EN = 32'h0000_0008;
  localparam logic [31:0] GPI_REG_IN_VAL = 32'h0000_000C;
  localparam logic [31:0] GPI_REG_PULL_EN = 32'h0000_0010;
  localparam logic [31:0] GPI_REG_PULL_UP = 32'h0000_0014;
  localparam logic [31:0] GPI_REG_DRIVE_HI = 32'h0000_0018;
  localparam logic [31:0] GPI_REG_INT_EN = 32'h0000_001C;
  localparam logic [31:0] GPI_REG_INT_EDGE = 32'h0000_0020;
  localparam logic [31:0] GPI_REG_INT_POL = 32'h0000_0024;
  localparam logic [31:0] GPI_REG_INT_STAT = 32'h0000_0028;
  localparam logic [31:0] GPI_REG_WAKE_EN = 32'h0000_002C;
  localparam logic [31:0] GPI_REG_WAKE_RISE = 32'h0000_0030;
  localparam logic [31:0] GPI_REG_WAKE_STAT = 32'h0000_0034;

  // Number of register words and width of the word index.
  localparam int GPI_NUM_REGS = 14;
  localparam int GPI_IDX_W = 4;

  // Value of every register word after reset.
  localparam logic [31:0] GPI_RST_VAL = 32'h0000_0000;

  // AXI response codes.
  localparam logic [1:0] GPI_RESP_OKAY = 2'h0;
  localparam logic [1:0] GPI_RESP_SLVERR = 2'h2;

  // Signals driven by the bus master.
  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } gpi_axi_req_t;

  // Signals driven by this slave.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } gpi_axi_rsp_t;

endpackage

/* File: testbench/gpi_port_checker.sv */
// Checker for the GPIO port: bus timing, pad control and request outputs.
// Assumes it is bound to the port and sees only the port's own pins.
`timescale 1ns/100ps
module gpi_port_checker #(
  parameter int N_PINS = 32
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire gpi_pkg::gpi_axi_req_t i_axi,
  input wire gpi_pkg::gpi_axi_rsp_t o_axi,
  input wire logic [N_PINS-1:0] i_pad_in,
  input wire logic [N_PINS-1:0] o_pad_oe_n,
  input wire logic [N_PINS-1:0] o_pull_up_en,
  input wire logic [N_PINS-1:0] o_pull_dn_en,
  input wire logic [N_PINS-1:0] o_alt_in,
  input wire logic o_irq,
  input wire logic o_wake
);
  import gpi_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Address and data taken together, then the answer one idle cycle later.
  sequence wr_take;
    i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready;
  endsequence
  sequence b_answer;
    !o_axi.bvalid ##1 o_axi.bvalid;
  endsequence
  // Bus timing follows the hand-over latencies.
  write_answer_a: assert property (wr_take |=> b_answer)
    else $error("write answer late");
  b_release_a: assert property (o_axi.bvalid && i_axi.bready |=>
    !o_axi.bvalid && o_axi.awready && o_axi.wready) else $error("write channel not freed");
  read_answer_a: assert property (i_axi.arvalid && o_axi.arready |=>
    o_axi.rvalid && !o_axi.arready) else $error("read answer late");
  r_release_a: assert property (o_axi.rvalid && i_axi.rready |=>
    !o_axi.rvalid && o_axi.arready) else $error("read channel not freed");
  // Pad state right after reset, pull sanity and input synchronisation.
  reset_state_a: assert property ($past(i_rst) |-> o_pad_oe_n == '1 && !o_irq && !o_wake
    && o_pull_up_en == '0 && o_pull_dn_en == '0) else $error("reset state wrong");
  pull_excl_a: assert property ((o_pull_up_en & o_pull_dn_en) == '0)
    else $error("both pulls on");
  pull_input_a: assert property (((o_pull_up_en | o_pull_dn_en) & ~o_pad_oe_n) == '0)
    else $error("pull on driven pad");
  sync_in_a: assert property (!$past(i_rst) && !$past(i_rst, 2) && !$past(i_rst, 3) |->
    o_alt_in == $past(i_pad_in, 3)) else $error("input sync latency wrong");
  // Requests fall only around a register write.
  irq_latch_a: assert property ($fell(o_irq) |-> o_axi.bvalid || $past(o_axi.bvalid))
    else $error("irq dropped without write");
  wake_latch_a: assert property ($fell(o_wake) |-> o_axi.bvalid || $past(o_axi.bvalid))
    else $error("wake dropped without write");
endmodule
bind gpi_port gpi_port_checker #(.N_PINS(N_PINS)) u_checker (.i_clk(i_clk), .i_rst(i_rst),
  .i_axi(i_axi), .o_axi(o_axi), .i_pad_in(i_pad_in), .o_pad_oe_n(o_pad_oe_n),
  .o_pull_up_en(o_pull_up_en), .o_pull_dn_en(o_pull_dn_en), .o_alt_in(o_alt_in),
  .o_irq(o_irq), .o_wake(o_wake));

/* File: testbench/gpi_board.sv */
// Board model: resolves each pad from port drive, board source and pulls.
// Assumes the port drives a pad while its output enable is low.
`timescale 1ns/100ps
module gpi_board (
  input wire logic [31:0] i_out,
  input wire logic [31:0] i_oe_n,
  input wire logic [31:0] i_up,
  input wire logic [31:0] i_dn,
  input wire logic [31:0] i_ext,
  input wire logic [31:0] i_ext_en,
  output logic [31:0] o_pad
);
  // A floating pad shows the inverse of the source so it never looks settled.
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (!i_oe_n[i]) o_pad[i] = i_out[i];
      else if (i_ext_en[i]) o_pad[i] = i_ext[i];
      else if (i_up[i]) o_pad[i] = 1'b1;
      else if (i_dn[i]) o_pad[i] = 1'b0;
      else o_pad[i] = ~i_ext[i];
    end
  end
endmodule

/* File: testbench/gpi_port_bench.sv */
// Bench for the GPIO port: bus tasks, board model and one task per scenario.
// Assumes a 250 MHz clock and the register map of the package.
`timescale 1ns/100ps
module gpi_port_bench;
  import gpi_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  gpi_axi_req_t req = '0;
  gpi_axi_rsp_t rsp;
  logic [31:0] pad, out, oe_n, up, dn, drv, alt_in, alt_out = '0, alt_oe = '0, ext = '0;
  logic [31:0] ext_en = '1;
  logic irq, wake;
  int n_errors = 0, n_tests = 0, cyc = 0;
  gpi_port u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_axi(req), .o_axi(rsp),
    .i_pad_in(pad), .o_pad_out(out), .o_pad_oe_n(oe_n), .o_pull_up_en(up),
    .o_pull_dn_en(dn), .o_drive_hi(drv), .i_alt_out(alt_out), .i_alt_oe(alt_oe),
    .o_alt_in(alt_in), .o_irq(irq), .o_wake(wake));
  gpi_board u_board (.i_out(out), .i_oe_n(oe_n), .i_up(up), .i_dn(dn), .i_ext(ext),
    .i_ext_en(ext_en), .o_pad(pad));
  always #2 i_clk = ~i_clk;
  // Cuts a hung run short.
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Write: address and data offered together, each released once taken.
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  // Covers pad, synchroniser and status latency.
  task automatic settle();
    repeat (6) @(posedge i_clk);
  endtask
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    ext <= 32'hA5A5_5A5A;
    chk(oe_n, '1);
    chk(up | dn | drv, '0);
    for (int i = 0; i < GPI_NUM_REGS; i++) begin
      rd(32'(4 * i), d, r);
      chk(d, (i == 3) ? 32'hA5A5_5A5A : GPI_RST_VAL);
    end
    rd(32'h0000_0038, d, r);
    chk(32'(r), 32'(GPI_RESP_SLVERR));
    wr(32'h0000_0038, '1, r);
    chk(32'(r), 32'(GPI_RESP_SLVERR));
    $display("reset test done");
  endtask
  task automatic t_gpio();
    logic [31:0] d;
    logic [1:0] r;
    wr(GPI_REG_OUT_VAL, 32'h1234_5678, r);
    wr(GPI_REG_OUT_EN, 32'hFFFF_0000, r);
    wr(GPI_REG_DRIVE_HI, 32'h8000_0001, r);
    settle();
    chk(oe_n, 32'h0000_FFFF);
    chk(out & ~oe_n, 32'h1234_0000);
    chk(drv, 32'h8000_0001);
    rd(GPI_REG_IN_VAL, d, r);
    chk(d, 32'h1234_5A5A);
    ext_en <= '0;
    wr(GPI_REG_PULL_EN, '1, r);
    wr(GPI_REG_PULL_UP, 32'h0000_00FF, r);
    settle();
    chk(up, 32'h0000_00FF);
    chk(dn, 32'h0000_FF00);
    rd(GPI_REG_IN_VAL, d, r);
    chk(d, 32'h1234_00FF);
    wr(GPI_REG_PULL_EN, '0, r);
    ext_en <= '1;
    $display("pin mode test done");
  endtask
  task automatic t_alt();
    logic [1:0] r;
    alt_out <= 32'h0000_0003;
    alt_oe <= 32'h0000_0005;
    wr(GPI_REG_FUNC_SEL, 32'h0000_000F, r);
    settle();
    chk(oe_n, 32'h0000_FFFA);
    chk(out & 32'h0000_0005, 32'h0000_0001);
    chk(alt_in & 32'h0000_000F, 32'h0000_000B);
    wr(GPI_REG_FUNC_SEL, '0, r);
    settle();
    chk(oe_n, 32'h0000_FFFF);
    $display("peripheral test done");
  endtask
  task automatic t_irq();
    logic [31:0] d;
    logic [1:0] r;
    ext <= '0;
    wr(GPI_REG_OUT_EN, '0, r);
    wr(GPI_REG_INT_EDGE, 32'h8000_0001, r);
    wr(GPI_REG_INT_POL, 32'h0000_0003, r);
    wr(GPI_REG_INT_EN, 32'h8000_0003, r);
    ext <= 32'h8000_0004;
    settle();
    chk(32'(irq), 32'h0);
    ext <= 32'h0000_0001;
    settle();
    rd(GPI_REG_INT_STAT, d, r);
    chk(d, 32'h8000_0001);
    chk(32'(irq), 32'h1);
    wr(GPI_REG_INT_STAT, 32'h8000_0001, r);
    settle();
    chk(32'(irq), 32'h0);
    ext <= 32'h0000_0003;
    settle();
    wr(GPI_REG_INT_STAT, 32'h0000_0002, r);
    settle();
    rd(GPI_REG_INT_STAT, d, r);
    chk(d, 32'h0000_0002);
    ext <= 32'h0000_0001;
    settle();
    wr(GPI_REG_INT_STAT, 32'h0000_0002, r);
    settle();
    chk(32'(irq), 32'h0);
    $display("interrupt test done");
  endtask
  task automatic t_wake();
    logic [31:0] d;
    logic [1:0] r;
    wr(GPI_REG_WAKE_EN, 32'h0000_0010, r);
    ext <= 32'h0000_0011;
    settle();
    chk(32'(wake), 32'h0);
    ext <= 32'h0000_0001;
    settle();
    chk(32'(wake), 32'h1);
    rd(GPI_REG_WAKE_STAT, d, r);
    chk(d, 32'h0000_0010);
    wr(GPI_REG_WAKE_STAT, 32'h0000_0010, r);
    settle();
    chk(32'(wake), 32'h0);
    wr(GPI_REG_WAKE_RISE, 32'h0000_0010, r);
    ext <= 32'h0000_0011;
    settle();
    chk(32'(wake), 32'h1);
    wr(GPI_REG_WAKE_STAT, 32'h0000_0010, r);
    settle();
    chk(32'(wake), 32'h0);
    $display("wake test done");
  endtask
  // Reset, then the scenarios in order.
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_reset();
    t_gpio();
    t_alt();
    t_irq();
    t_wake();
    test_done();
  end
endmodule
